/* File: hdl/billboard_consts.svh */
`ifndef BILLBOARD_CONSTS_SVH
`define BILLBOARD_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_IDLE_TMO_LOW 16'h413C
`define IDX_IDLE_TMO_HIGH 16'h413D
`define IDX_BB_CONTROL 16'h4140
`define IDX_BB_STATUS 16'h4141
`define IDX_STRING_TMO_LOW 16'h4142
`define IDX_STRING_TMO_HIGH 16'h4143

// Reset values
`define RST_IDLE_TMO_LOW 8'hD0
`define RST_IDLE_TMO_HIGH 8'h07
`define RST_BB_CONTROL 8'h14
`define RST_STRING_TMO 16'h07D0

// Control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 5
`define CTRL_WRITE_MASK 8'h3F

// Pin select codes
`define SEL_RESERVED 5'h09
`define SEL_LAST 5'h10
`define NUM_PINS 17

// Descriptor field reported while billboard is shown (unspecified error)
`define BM_CONFIGURED_UNSPEC 2'h0

// Timing
`define CLK_FREQ_KHZ 250000
`define TICK_PERIOD_MS 10
`define DETACH_HOLD_TICKS 4'h2

`endif

/* File: hdl/billboard_fallback_sequencer.sv */
// Summary of operation
// (RQ1) Request comes from one of 17 pins picked by a 5-bit select; 01010 default.
// (RQ2) Request input is active low; low means alternate-mode negotiation failed.
// (RQ3) Control bit 0 enables the whole billboard feature.
// (RQ4) Control bits 7:6 always read zero.
// (RQ5) On request, first force the function device off its hub port.
// (RQ6) Then reconnect it with billboard class 1.1 descriptors.
// (RQ7) Start idle timer when host assigns the billboard device an address.
// (RQ8) Show billboard only on failure; report bmConfigured as unspecified error.
// (RQ9) On alternate-mode string request, start the string timer, default 20 s.
// (RQ10) When either timer expires, force the function device off its port again.
// (RQ11) Then reconnect it with its standard identity.
// (RQ12) Idle timeout is 16 bits in low and high bytes, 10 ms per count.
// (RQ13) Idle timeout resets to D0h and 07h, 2000 counts or 20 s.
// (RQ14) Derive a 10 ms tick to run both timers; clear timers on sequence exit.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "billboard_consts.svh"
module billboard_fallback_sequencer #(
	parameter int unsigned TICK_CYCLES = `TICK_PERIOD_MS * `CLK_FREQ_KHZ
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request pins from the power-delivery controller, active low
	input wire logic [`NUM_PINS-1:0] general_purpose_pin,
	// Events from the internal function device
	input wire logic addr_set_pulse,
	input wire logic string_req_pulse,
	// Control of the internal function device
	output billboard_pkg::func_ctrl_t func_ctrl
);
	import billboard_pkg::*;

	// Byte addresses: each register sits alone in one aligned word
	localparam logic [31:0] ADDR_IDLE_LOW = {14'h0, `IDX_IDLE_TMO_LOW, 2'b00};
	localparam logic [31:0] ADDR_IDLE_HIGH = {14'h0, `IDX_IDLE_TMO_HIGH, 2'b00};
	localparam logic [31:0] ADDR_CONTROL = {14'h0, `IDX_BB_CONTROL, 2'b00};
	localparam logic [31:0] ADDR_STATUS = {14'h0, `IDX_BB_STATUS, 2'b00};
	localparam logic [31:0] ADDR_STR_LOW = {14'h0, `IDX_STRING_TMO_LOW, 2'b00};
	localparam logic [31:0] ADDR_STR_HIGH = {14'h0, `IDX_STRING_TMO_HIGH, 2'b00};

	bb_control_t ctrl_q;
	logic [15:0] idle_tmo_q;
	logic [15:0] str_tmo_q;
	seq_state_t state_q;
	logic [3:0] hold_q;
	logic [15:0] idle_cnt_q;
	logic idle_run_q;
	logic [15:0] str_cnt_q;
	logic str_run_q;
	logic req_low_q;
	logic [`NUM_PINS-1:0] pins_sync;
	logic tick;
	logic setup;
	logic wr_access;
	logic expire;
	logic [7:0] status;
	logic hit_idle_low;
	logic hit_idle_high;
	logic hit_control;
	logic hit_status;
	logic hit_str_low;
	logic hit_str_high;
	logic req_sel;
	logic [7:0] rd_byte;
	logic rd_err;
	logic in_billboard;
	logic idle_start;
	logic str_start;
	logic idle_expire;
	logic str_expire;

	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;

	// Register decode, shared by the write side and the read side
	assign hit_idle_low = paddr == ADDR_IDLE_LOW;
	assign hit_idle_high = paddr == ADDR_IDLE_HIGH;
	assign hit_control = paddr == ADDR_CONTROL;
	assign hit_status = paddr == ADDR_STATUS;
	assign hit_str_low = paddr == ADDR_STR_LOW;
	assign hit_str_high = paddr == ADDR_STR_HIGH;

	// Host events count only while the billboard identity is shown
	assign in_billboard = state_q == ST_BB_ATTACHED;
	assign idle_start = in_billboard && !idle_run_q && addr_set_pulse; // RQ7
	assign str_start = in_billboard && !str_run_q && string_req_pulse; // RQ9

	// 10 ms time base; both timers and the detach hold share it, so every time
	// is exact to one tick, not to one cycle
	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick) // RQ14
	);

	// Three flip-flops against metastability on the asynchronous request pins
	pin_sync #(
		.WIDTH(`NUM_PINS)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(general_purpose_pin),
		.pin_out(pins_sync)
	);

	// Request through the current select, so that rewriting the select never acts on
	// the level of the pin chosen before; reserved or out-of-range codes never request
	always_comb begin
		req_sel = 1'b0;
		if (ctrl_q.pin_sel != `SEL_RESERVED && ctrl_q.pin_sel <= `SEL_LAST) begin
			req_sel = !pins_sync[ctrl_q.pin_sel]; // RQ1 RQ2
		end
	end

	// Request level kept for the status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_low_q <= 1'b0;
		end else begin
			req_low_q <= req_sel;
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= bb_control_t'(`RST_BB_CONTROL);
		end else if (wr_access && hit_control) begin
			// Bits 7:6 are dropped here so that they always read zero
			ctrl_q <= bb_control_t'(pwdata[7:0] & `CTRL_WRITE_MASK); // RQ4
		end
	end

	// Idle timeout reload, low and high bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_tmo_q <= {`RST_IDLE_TMO_HIGH, `RST_IDLE_TMO_LOW}; // RQ13
		end else if (wr_access && hit_idle_low) begin
			idle_tmo_q[7:0] <= pwdata[7:0]; // RQ12
		end else if (wr_access && hit_idle_high) begin
			idle_tmo_q[15:8] <= pwdata[7:0]; // RQ12
		end
	end

	// String timeout reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			str_tmo_q <= `RST_STRING_TMO; // RQ9
		end else if (wr_access && hit_str_low) begin
			str_tmo_q[7:0] <= pwdata[7:0];
		end else if (wr_access && hit_str_high) begin
			str_tmo_q[15:8] <= pwdata[7:0];
		end
	end

	// Status: request seen, timer run flags and the function device state
	assign status = {3'h0, req_low_q, str_run_q, idle_run_q, func_ctrl.billboard_id,
		func_ctrl.detach};

	// Read data for the addressed register; an unmapped address is refused
	always_comb begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		if (hit_idle_low) begin
			rd_byte = idle_tmo_q[7:0];
		end else if (hit_idle_high) begin
			rd_byte = idle_tmo_q[15:8];
		end else if (hit_control) begin
			rd_byte = {2'h0, ctrl_q.pin_sel, ctrl_q.enable}; // RQ4
		end else if (hit_status) begin
			rd_byte = status;
		end else if (hit_str_low) begin
			rd_byte = str_tmo_q[7:0];
		end else if (hit_str_high) begin
			rd_byte = str_tmo_q[15:8];
		end else begin
			rd_err = 1'b1;
		end
	end

	// APB answer: data and ready registered in the setup cycle, one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup) begin
			// Writes land at the access edge through wr_access; ready is never held off
			pready <= 1'b1;
			pslverr <= rd_err;
			prdata <= {24'h0, rd_byte};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// A timer loaded with N expires on the Nth tick after it starts
	assign idle_expire = tick && idle_run_q && idle_cnt_q <= 16'h1;
	assign str_expire = tick && str_run_q && str_cnt_q <= 16'h1;
	assign expire = idle_expire || str_expire; // RQ10

	// Idle detach timer; an address pulse while it runs does not restart it,
	// so a host that readdresses the device cannot keep the billboard forever
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_run_q <= 1'b0;
			idle_cnt_q <= 16'h0;
		end else if (!in_billboard) begin
			idle_run_q <= 1'b0; // RQ14
			idle_cnt_q <= 16'h0;
		end else if (idle_start) begin
			idle_run_q <= 1'b1; // RQ7
			idle_cnt_q <= idle_tmo_q;
		end else if (idle_run_q && tick && idle_cnt_q != 16'h0) begin
			idle_cnt_q <= idle_cnt_q - 16'h1; // RQ12
		end
	end

	// String detach timer; a repeated string fetch does not restart it,
	// the first fetch fixes the moment of the detach
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			str_run_q <= 1'b0;
			str_cnt_q <= 16'h0;
		end else if (!in_billboard) begin
			str_run_q <= 1'b0; // RQ14
			str_cnt_q <= 16'h0;
		end else if (str_start) begin
			str_run_q <= 1'b1; // RQ9
			str_cnt_q <= str_tmo_q;
		end else if (str_run_q && tick && str_cnt_q != 16'h0) begin
			str_cnt_q <= str_cnt_q - 16'h1;
		end
	end

	// Detach and re-attach sequence. A new sequence needs the request to go away,
	// or the enable bit to clear, first; otherwise a pin still held low would cycle
	// the function device between its two identities without end.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_NORMAL;
			hold_q <= 4'h0;
		end else begin
			unique case (state_q)
				ST_NORMAL: begin
					if (ctrl_q.enable && req_sel) begin // RQ3
						state_q <= ST_DETACH_IN; // RQ5
						hold_q <= `DETACH_HOLD_TICKS;
					end
				end
				ST_DETACH_IN: begin
					// Hold the detach for whole ticks so the host sees a real disconnect
					if (tick && hold_q <= 4'h1) begin
						state_q <= ST_BB_ATTACHED; // RQ6
					end else if (tick) begin
						hold_q <= hold_q - 4'h1;
					end
				end
				ST_BB_ATTACHED: begin
					if (expire || !ctrl_q.enable) begin
						state_q <= ST_DETACH_OUT; // RQ10
						hold_q <= `DETACH_HOLD_TICKS;
					end
				end
				ST_DETACH_OUT: begin
					// Second detach, then the standard identity comes back
					if (tick && hold_q <= 4'h1) begin
						state_q <= ST_WAIT_RELEASE; // RQ11
					end else if (tick) begin
						hold_q <= hold_q - 4'h1;
					end
				end
				ST_WAIT_RELEASE: begin
					// A pin still held low must be released, or the enable bit cleared, before a new sequence
					if (!req_sel || !ctrl_q.enable) begin
						state_q <= ST_NORMAL;
					end
				end
			endcase
		end
	end

	// Function device control, registered; bm_configured is fixed because only
	// the failure case is ever shown to the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_ctrl <= '{detach: 1'b0, billboard_id: 1'b0, bm_configured: `BM_CONFIGURED_UNSPEC};
		end else begin
			func_ctrl.detach <= (state_q == ST_DETACH_IN || state_q == ST_DETACH_OUT); // RQ5 RQ10
			func_ctrl.billboard_id <= (state_q == ST_BB_ATTACHED); // RQ6 RQ8 RQ11
			func_ctrl.bm_configured <= `BM_CONFIGURED_UNSPEC; // RQ8
		end
	end
endmodule

/* File: hdl/billboard_pkg.sv */
package billboard_pkg;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_DETACH_IN,
		ST_BB_ATTACHED,
		ST_DETACH_OUT,
		ST_WAIT_RELEASE
	} seq_state_t;

	typedef struct packed {
		logic [1:0] rsvd;
		logic [4:0] pin_sel;
		logic enable;
	} bb_control_t;

	typedef struct packed {
		logic detach;
		logic billboard_id;
		logic [1:0] bm_configured;
	} func_ctrl_t;

endpackage

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned WIDTH = 17
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins in, filtered levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// Pins idle high; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			pin_out <= '1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

/* File: hdl/tick_divider.sv */
`timescale 1ns/1ps
module tick_divider #(
	parameter int unsigned CYCLES = 2500000
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Enable pulse
	output logic tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_q >= CYCLES[31:0] - 32'h1) begin
			cnt_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule

/* File: sim/billboard_fallback_sequencer_monitor.sv */
`timescale 1ns/1ps
module billboard_fallback_sequencer_monitor #(
	parameter int unsigned TICK_CYCLES = 2500000
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and function device
	input wire logic [16:0] general_purpose_pin,
	input wire logic addr_set_pulse,
	input wire logic string_req_pulse,
	input wire billboard_pkg::func_ctrl_t func_ctrl
);
	import billboard_pkg::*;
	int unsigned hold_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Length of the current detach period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hold_q <= 0;
		else hold_q <= func_ctrl.detach ? hold_q + 1 : 0;
	end
	a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
	a_rsvd_zero: assert property (pready && !pwrite && paddr == 32'h10500 |->
		prdata[31:6] == 26'h0) else $error("reserved bits set");
	a_unmapped_err: assert property (pready && paddr == 32'h0 |-> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	a_bm_unspec: assert property (func_ctrl.bm_configured == 2'h0) else $error("bad bm");
	a_detach_first: assert property ($rose(func_ctrl.billboard_id) |->
		$past(func_ctrl.detach)) else $error("no detach first");
	a_ident_exclusive: assert property (!(func_ctrl.detach && func_ctrl.billboard_id))
		else $error("detached and attached");
	a_expiry_detach: assert property ($fell(func_ctrl.billboard_id) |->
		func_ctrl.detach[*8]) else $error("no expiry detach");
	a_hold_bounded: assert property (hold_q <= 2 * TICK_CYCLES + 8)
		else $error("detach held too long");
endmodule
bind billboard_fallback_sequencer billboard_fallback_sequencer_monitor #(
	.TICK_CYCLES(TICK_CYCLES)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .general_purpose_pin(general_purpose_pin),
	.addr_set_pulse(addr_set_pulse), .string_req_pulse(string_req_pulse),
	.func_ctrl(func_ctrl));

/* File: sim/billboard_fallback_sequencer_tb.sv */
`timescale 1ns/1ps
module billboard_fallback_sequencer_tb;
	import billboard_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [16:0] pins;
	logic adr_p;
	logic str_p;
	func_ctrl_t func_ctrl;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	logic [31:0] rd;
	logic er;
	always #2 pclk = ~pclk;
	billboard_fallback_sequencer #(.TICK_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .general_purpose_pin(pins),
		.addr_set_pulse(adr_p), .string_req_pulse(str_p), .func_ctrl(func_ctrl));
	pd_partner partner (.pclk(pclk), .pins(pins), .addr_set(adr_p), .str_req(str_p));
	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0, i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input string nm, input logic [15:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(nm, rd, {24'h0, e});
	endtask
	// Cycles until detach (f=0) or billboard identity (f=1) reads v
	task wait_fc(input logic f, input logic v);
		n = 0;
		while ((f ? func_ctrl.billboard_id : func_ctrl.detach) !== v && n < 400) begin
			@(negedge pclk);
			n++;
		end
	endtask
	task t_reset();
		rchk("idle_low", 16'h413C, 8'hD0);
		rchk("idle_high", 16'h413D, 8'h07);
		rchk("control", 16'h4140, 8'h14);
		rchk("str_low", 16'h4142, 8'hD0);
		rchk("str_high", 16'h4143, 8'h07);
		apb(1'b0, 16'h0000, 8'h00);
		chk("unmapped_err", {31'h0, er}, 32'h1);
	endtask
	task t_regs();
		apb(1'b1, 16'h4140, 8'hFE);
		rchk("ctrl_rsvd", 16'h4140, 8'h3E);
		apb(1'b1, 16'h413C, 8'h05);
		apb(1'b1, 16'h413D, 8'h00);
		rchk("idle_rw", 16'h413C, 8'h05);
		apb(1'b1, 16'h4140, 8'h14);
	endtask
	// Feature off, then the reserved select: a low pin changes nothing
	task t_refuse();
		partner.drive(17'h0);
		repeat (100) @(negedge pclk);
		chk("off_detach", {31'h0, func_ctrl.detach}, 32'h0);
		apb(1'b1, 16'h4140, 8'h13);
		repeat (100) @(negedge pclk);
		chk("rsvd_detach", {31'h0, func_ctrl.detach}, 32'h0);
		apb(1'b1, 16'h4140, 8'h14);
		partner.drive(17'h1FFFF);
	endtask
	// Fallback on pin c, ended by the idle (s=0) or string (s=1) timer
	task t_fallback(input int c, input logic s, input int lo, input int hi);
		apb(1'b1, 16'h4140, {2'h0, c[4:0], 1'b1});
		partner.drive(~(17'h1 << c));
		wait_fc(1'b0, 1'b1);
		chk("detach_in", {31'h0, func_ctrl.detach}, 32'h1);
		wait_fc(1'b1, 1'b1);
		chk("bb_id", {31'h0, func_ctrl.billboard_id}, 32'h1);
		chk("bm_cfg", {30'h0, func_ctrl.bm_configured}, 32'h0);
		partner.pulse(s);
		rchk("timer_run", 16'h4141, {3'h0, 1'b1, s, !s, 1'b1, 1'b0});
		wait_fc(1'b0, 1'b1);
		chk("expiry_time", {31'h0, n >= lo && n <= hi}, 32'h1);
		chk("bb_off", {31'h0, func_ctrl.billboard_id}, 32'h0);
		wait_fc(1'b0, 1'b0);
		chk("std_attach", {31'h0, func_ctrl.billboard_id}, 32'h0);
		partner.drive(17'h1FFFF);
		repeat (10) @(negedge pclk);
		rchk("timers_clr", 16'h4141, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_refuse();
		t_fallback(10, 1'b0, 76, 106);
		apb(1'b1, 16'h4142, 8'h02);
		apb(1'b1, 16'h4143, 8'h00);
		t_fallback(16, 1'b1, 16, 46);
		print_verdict();
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end
endmodule

/* File: sim/pd_partner.sv */
`timescale 1ns/1ps
module pd_partner (
	// Clock
	input wire logic pclk,
	// Request pins and host events
	output logic [16:0] pins,
	output logic addr_set,
	output logic str_req
);
	// Pins idle high as if pulled up
	initial begin
		pins = 17'h1FFFF;
		addr_set = 1'b0;
		str_req = 1'b0;
	end
	// A failure report holds a pin low
	task drive(input logic [16:0] v);
		@(posedge pclk);
		pins <= v;
	endtask
	// Host event: address set or string fetched
	task pulse(input logic s);
		@(posedge pclk);
		if (s) str_req <= 1'b1;
		else addr_set <= 1'b1;
		@(posedge pclk);
		addr_set <= 1'b0;
		str_req <= 1'b0;
	endtask
endmodule
